// file: rtl/dcps_pkg.sv
package dcps_pkg;
	// Command encoding {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_ZQ = 4'h6;
	// Timing counts in clock cycles, then the counter width in bits
	localparam int CKE_MIN_NCK = 3;
	localparam int MRD_NCK = 4;
	localparam int MOD_NCK = 12;
	localparam int XS_NCK = 30;
	localparam int XSDLL_NCK = 512;
	localparam int WR_AFTER_SRX_NCK = 512;
	localparam int XP_NCK = 3;
	localparam int RFC_NCK = 26;
	localparam int RP_NCK = 6;
	localparam int BURST_NCK = 4;
	localparam int CNT_W = 10;
	// Power states of the memory
	typedef enum logic [2:0] {
		ST_IDLE, ST_ACTIVE, ST_BUSY, ST_REFRESHING, ST_ACT_PD, ST_PRE_PD, ST_SELF_REF, ST_EXIT_WAIT
	} dcps_state_type;
endpackage

// file: rtl/dcps_if.sv
interface dcps_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	modport mem (input cke, input cs_n, input ras_n, input cas_n, input we_n);
	modport ctl (output cke, output cs_n, output ras_n, output cas_n, output we_n);
endinterface

// file: rtl/dcps_mem.sv
module dcps_mem (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	dcps_if.mem link,
	input wire logic odt_req,
	output logic [2:0] state_o,
	output logic idle_o,
	output logic refresh_run_o,
	output logic odt_on_o,
	output logic illegal_o
);
	dcps_pkg::dcps_state_type state_r, state_nxt;
	logic cke_s1_r, cke_s2_r, cke_prev_r, cke_prev_nxt;
	logic cke_s1_nxt, cke_s2_nxt;
	logic [3:0] cmd_s1_r, cmd_s2_r, cmd_s1_nxt, cmd_s2_nxt;
	logic [2:0] state_o_nxt;
	logic idle_o_nxt, refresh_run_o_nxt, odt_on_o_nxt, illegal_o_nxt;
	logic [dcps_pkg::CNT_W-1:0] busy_r, busy_nxt;
	logic illegal_r, illegal_nxt;
	logic odt_r, odt_nxt;
	logic [3:0] cmd;
	logic desnop;
	logic idle;

	// Pins come from the controller: two stages before use
	always_comb begin
		cke_s1_nxt = link.cke;
		cke_s2_nxt = cke_s1_r;
		cmd_s1_nxt = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
		cmd_s2_nxt = cmd_s1_r;
	end

	// Stages reset to CKE high and deselect, the controller's reset levels
	// Resetting CKE low here would fake a CKE-low sequence right after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			cke_s1_r <= 1'b1;
			cke_s2_r <= 1'b1;
			cmd_s1_r <= 4'hF;
			cmd_s2_r <= 4'hF;
		end else if (ce) begin
			cke_s1_r <= cke_s1_nxt;
			cke_s2_r <= cke_s2_nxt;
			cmd_s1_r <= cmd_s1_nxt;
			cmd_s2_r <= cmd_s2_nxt;
		end
	end

	// Decode; deselect ignores the strobes
	always_comb begin
		cmd = cmd_s2_r;
		desnop = cmd[3] || (cmd == dcps_pkg::CMD_NOP);
		idle = (state_r == dcps_pkg::ST_IDLE) && cke_prev_r && (busy_r == '0);
	end

	// State transitions on CKE(N-1), CKE(N) and current state
	always_comb begin
		state_nxt = state_r;
		busy_nxt = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
		cke_prev_nxt = cke_s2_r;
		illegal_nxt = 1'b0;
		odt_nxt = odt_req && (state_r != dcps_pkg::ST_SELF_REF);
		unique case ({cke_prev_r, cke_s2_r})
			2'b00: begin
				// Low-power states keep state, commands ignored
				if (state_r != dcps_pkg::ST_ACT_PD && state_r != dcps_pkg::ST_PRE_PD
					&& state_r != dcps_pkg::ST_SELF_REF) begin
					illegal_nxt = 1'b1;
				end
				if (state_r == dcps_pkg::ST_ACT_PD || state_r == dcps_pkg::ST_PRE_PD) begin
					busy_nxt = busy_r;
				end
			end
			2'b01: begin
				if (!desnop) begin
					illegal_nxt = 1'b1;
				end else if (state_r == dcps_pkg::ST_SELF_REF) begin
					state_nxt = dcps_pkg::ST_EXIT_WAIT;
					busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::XSDLL_NCK);
				end else if (state_r == dcps_pkg::ST_ACT_PD) begin
					state_nxt = dcps_pkg::ST_ACTIVE;
				end else if (state_r == dcps_pkg::ST_PRE_PD) begin
					state_nxt = dcps_pkg::ST_EXIT_WAIT;
					busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::XP_NCK);
				end else begin
					illegal_nxt = 1'b1;
				end
			end
			2'b10: begin
				if (cmd == dcps_pkg::CMD_REF && idle) begin
					state_nxt = dcps_pkg::ST_SELF_REF;
				end else if (cmd == dcps_pkg::CMD_REF) begin
					illegal_nxt = 1'b1;
				end else if (!desnop) begin
					illegal_nxt = 1'b1;
				end else if (state_r == dcps_pkg::ST_ACTIVE) begin
					state_nxt = dcps_pkg::ST_ACT_PD;
				end else begin
					state_nxt = dcps_pkg::ST_PRE_PD;
				end
			end
			2'b11: begin
				// Normal command flow; bank tracking is a single open flag
				if (busy_r == '0 && (state_r == dcps_pkg::ST_BUSY || state_r == dcps_pkg::ST_REFRESHING
					|| state_r == dcps_pkg::ST_EXIT_WAIT)) begin
					state_nxt = dcps_pkg::ST_IDLE;
				end
				if (!cmd[3]) begin
					unique case (cmd)
						dcps_pkg::CMD_ACT: state_nxt = dcps_pkg::ST_ACTIVE;
						dcps_pkg::CMD_PRE: begin
							state_nxt = dcps_pkg::ST_BUSY;
							busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::RP_NCK);
						end
						dcps_pkg::CMD_REF: begin
							state_nxt = dcps_pkg::ST_REFRESHING;
							busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::RFC_NCK);
						end
						dcps_pkg::CMD_RD, dcps_pkg::CMD_WR: begin
							busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::BURST_NCK);
						end
						dcps_pkg::CMD_MRS: begin
							state_nxt = dcps_pkg::ST_BUSY;
							busy_nxt = dcps_pkg::CNT_W'(dcps_pkg::MOD_NCK);
						end
						dcps_pkg::CMD_ZQ, dcps_pkg::CMD_NOP: ;
					endcase
				end
			end
		endcase
	end

	// Output values follow the next state so the ports come straight from flops
	always_comb begin
		state_o_nxt = state_nxt;
		idle_o_nxt = (state_nxt == dcps_pkg::ST_IDLE) && cke_prev_nxt && (busy_nxt == '0);
		refresh_run_o_nxt = (state_nxt == dcps_pkg::ST_SELF_REF);
		odt_on_o_nxt = odt_nxt;
		illegal_o_nxt = illegal_nxt;
	end

	// State, counters and outputs; CKE history starts high like the pin
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= dcps_pkg::ST_IDLE;
			busy_r <= '0;
			cke_prev_r <= 1'b1;
			illegal_r <= 1'b0;
			odt_r <= 1'b0;
			state_o <= 3'h0;
			idle_o <= 1'b0;
			refresh_run_o <= 1'b0;
			odt_on_o <= 1'b0;
			illegal_o <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			busy_r <= busy_nxt;
			cke_prev_r <= cke_prev_nxt;
			illegal_r <= illegal_nxt;
			odt_r <= odt_nxt;
			state_o <= state_o_nxt;
			idle_o <= idle_o_nxt;
			refresh_run_o <= refresh_run_o_nxt;
			odt_on_o <= odt_on_o_nxt;
			illegal_o <= illegal_o_nxt;
		end
	end
endmodule // dcps_mem

// file: rtl/dcps_ctl.sv
// Controller end: honours CKE timing and DES/NOP windows
module dcps_ctl (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	dcps_if.ctl link,
	input wire logic pd_req,
	input wire logic sr_req,
	input wire logic wake_req,
	input wire logic [3:0] cmd_req,
	input wire logic cmd_valid,
	output logic cmd_ready,
	output logic low_power
);
	typedef enum logic [1:0] {C_RUN, C_PD, C_SR, C_WAIT} dcps_ctl_type;
	dcps_ctl_type st_r, st_nxt;
	logic cke_r, cke_nxt;
	logic [3:0] cmd_r, cmd_nxt;
	logic [dcps_pkg::CNT_W-1:0] hold_r, hold_nxt, wait_r, wait_nxt;
	logic [dcps_pkg::CNT_W-1:0] mod_r, mod_nxt;

	assign link.cke = cke_r;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_r;

	// Sequencing of CKE and command output
	always_comb begin
		st_nxt = st_r;
		cke_nxt = cke_r;
		cmd_nxt = 4'hF;
		hold_nxt = (hold_r != '0) ? hold_r - 1'b1 : hold_r;
		wait_nxt = (wait_r != '0) ? wait_r - 1'b1 : wait_r;
		mod_nxt = (mod_r != '0) ? mod_r - 1'b1 : mod_r;
		unique case (st_r)
			C_RUN: begin
				if ((pd_req || sr_req) && hold_r == '0 && mod_r == '0 && wait_r == '0) begin
					cke_nxt = 1'b0;
					cmd_nxt = sr_req ? dcps_pkg::CMD_REF : 4'hF;
					hold_nxt = dcps_pkg::CNT_W'(dcps_pkg::CKE_MIN_NCK - 1);
					st_nxt = sr_req ? C_SR : C_PD;
				end else if (cmd_valid && !cmd_req[3]) begin
					cmd_nxt = cmd_req;
					if (cmd_req == dcps_pkg::CMD_MRS) begin
						mod_nxt = dcps_pkg::CNT_W'(dcps_pkg::MOD_NCK + dcps_pkg::MRD_NCK);
					end
				end
			end
			C_PD, C_SR: begin
				if (wake_req && hold_r == '0) begin
					cke_nxt = 1'b1; // DES accompanies exit
					hold_nxt = dcps_pkg::CNT_W'(dcps_pkg::CKE_MIN_NCK - 1);
					wait_nxt = (st_r == C_SR) ? dcps_pkg::CNT_W'(dcps_pkg::WR_AFTER_SRX_NCK)
						: dcps_pkg::CNT_W'(dcps_pkg::XP_NCK);
					st_nxt = C_WAIT;
				end
			end
			C_WAIT: begin
				if (wait_r == '0) begin
					st_nxt = C_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= C_RUN;
			cke_r <= 1'b1;
			cmd_r <= 4'hF;
			hold_r <= '0;
			wait_r <= '0;
			mod_r <= '0;
			cmd_ready <= 1'b0;
			low_power <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			cke_r <= cke_nxt;
			cmd_r <= cmd_nxt;
			hold_r <= hold_nxt;
			wait_r <= wait_nxt;
			mod_r <= mod_nxt;
			cmd_ready <= (st_nxt == C_RUN) && !pd_req && !sr_req;
			low_power <= (st_nxt == C_PD) || (st_nxt == C_SR);
		end
	end
endmodule // dcps_ctl

// file: test/dcps_chk.sv
module dcps_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] state_o,
	input wire logic odt_on_o,
	input wire logic illegal_o
);
	logic quiet;
	logic cke_r;
	logic [9:0] srx_r;
	logic [9:0] srx_nxt;
	// Deselect or no-operation on the pins
	assign quiet = cs_n || {ras_n, cas_n, we_n} == 3'h7;
	// Cycles since a self-refresh exit edge
	always_comb begin
		srx_nxt = srx_r;
		if (srx_r != 10'h000) srx_nxt = srx_r + 10'h001;
		if (srx_r == 10'h1FF) srx_nxt = 10'h000;
		if (cke && !cke_r && state_o == dcps_pkg::ST_SELF_REF) srx_nxt = 10'h001;
	end
	always_ff @(posedge clock) begin
		srx_r <= rst ? 10'h000 : srx_nxt;
		cke_r <= rst ? 1'b1 : cke;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_CKE_HOLD: assert property ($changed(cke) |=> $stable(cke) [*2]) else $error("cke toggled early");
	AST_RISE_QUIET: assert property ($rose(cke) |-> quiet) else $error("cke rise with command");
	AST_SR_ENTRY: assert property ($fell(cke) && !quiet |-> ##3 state_o == dcps_pkg::ST_SELF_REF)
		else $error("no self refresh");
	AST_PD_ENTRY: assert property ($fell(cke) && quiet
		|-> ##3 state_o inside {dcps_pkg::ST_ACT_PD, dcps_pkg::ST_PRE_PD}) else $error("no power-down");
	AST_LOW_STAY: assert property (!cke && !cke_r |-> ##3 $stable(state_o)) else $error("left low state");
	AST_SRX_WAKE: assert property ($rose(cke) && state_o == dcps_pkg::ST_SELF_REF
		|-> ##3 state_o == dcps_pkg::ST_EXIT_WAIT) else $error("no exit wait");
	AST_SRX_QUIET: assert property (srx_r != 0 && srx_r < dcps_pkg::XS_NCK |-> quiet)
		else $error("command during exit");
	AST_SRX_NO_RW: assert property (srx_r != 0 |-> !(!cs_n && ras_n && !cas_n))
		else $error("early read or write");
	AST_SR_NO_ODT: assert property (state_o == dcps_pkg::ST_SELF_REF && $past(state_o) == dcps_pkg::ST_SELF_REF
		|-> !odt_on_o) else $error("odt on in self refresh");
	AST_NO_ILLEGAL: assert property (!illegal_o) else $error("illegal sequence seen");
endmodule // dcps_chk

// file: test/dram_cke_power_state_control_tb.sv
module dram_cke_power_state_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst = 1'b1, ce = 1'b1, odt_req = 1'b0, pd_req = 1'b0, sr_req = 1'b0;
	logic wake_req = 1'b0, cmd_valid = 1'b0, ill2_seen = 1'b0;
	logic [3:0] cmd_req = 4'h7;
	logic [2:0] state_o, st2;
	logic idle_o, refresh_run_o, odt_on_o, illegal_o, cmd_ready, low_power, ill2;
	int err_total = 0, checks = 0;
	time t0;
	dcps_if lnk();
	dcps_if lnk2();
	// Clock and sticky flag for the second memory
	always #5ns clock = ~clock;
	always @(posedge clock) if (ill2 === 1'b1) ill2_seen <= 1'b1;
	dcps_mem u_dcps_mem (.clock(clock), .rst(rst), .ce(ce), .link(lnk.mem), .odt_req(odt_req), .state_o(state_o),
		.idle_o(idle_o), .refresh_run_o(refresh_run_o), .odt_on_o(odt_on_o), .illegal_o(illegal_o));
	dcps_ctl u_dcps_ctl (.clock(clock), .rst(rst), .ce(ce), .link(lnk.ctl), .pd_req(pd_req), .sr_req(sr_req),
		.wake_req(wake_req), .cmd_req(cmd_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .low_power(low_power));
	dcps_mem u_dcps_mem_bad (.clock(clock), .rst(rst), .ce(ce), .link(lnk2.mem), .odt_req(odt_req), .state_o(st2),
		.idle_o(), .refresh_run_o(), .odt_on_o(), .illegal_o(ill2));
	dcps_chk u_dcps_chk (.clock(clock), .rst(rst), .cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
		.cas_n(lnk.cas_n), .we_n(lnk.we_n), .state_o(state_o), .odt_on_o(odt_on_o), .illegal_o(illegal_o));
	task check(input string nm, input logic [3:0] s, input logic [3:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wst(input logic [2:0] e, input int n);
		repeat (n) if (state_o !== e) @(negedge clock);
		check("state", {1'b0, state_o}, {1'b0, e});
	endtask
	task send(input logic [3:0] c);
		cmd_req = c;
		cmd_valid = 1'b1;
		repeat (700) if (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask
	task drv2(input logic c, input logic [3:0] cmd);
		lnk2.cke = c;
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = cmd;
		@(negedge clock);
	endtask
	task t_pd;
		pd_req = 1'b1;
		wst(dcps_pkg::ST_PRE_PD, 20);
		check("low_power", {3'h0, low_power}, 4'h1);
		pd_req = 1'b0;
		ce = 1'b0;
		wake_req = 1'b1;
		repeat (10) @(negedge clock);
		check("frozen_state", {1'b0, state_o}, {1'b0, dcps_pkg::ST_PRE_PD});
		check("frozen_cke", {3'h0, lnk.cke}, 4'h0);
		ce = 1'b1;
		wst(dcps_pkg::ST_IDLE, 40);
		wake_req = 1'b0;
	endtask
	task t_act_pd;
		send(dcps_pkg::CMD_ACT);
		pd_req = 1'b1;
		wst(dcps_pkg::ST_ACT_PD, 20);
		pd_req = 1'b0;
		wake_req = 1'b1;
		wst(dcps_pkg::ST_ACTIVE, 40);
		wake_req = 1'b0;
		send(dcps_pkg::CMD_PRE);
		wst(dcps_pkg::ST_IDLE, 40);
	endtask
	task t_sr;
		sr_req = 1'b1;
		odt_req = 1'b1;
		wst(dcps_pkg::ST_SELF_REF, 20);
		repeat (10) @(negedge clock);
		check("sr_state", {1'b0, state_o}, {1'b0, dcps_pkg::ST_SELF_REF});
		check("refresh_run", {3'h0, refresh_run_o}, 4'h1);
		check("odt_on", {3'h0, odt_on_o}, 4'h0);
		sr_req = 1'b0;
		odt_req = 1'b0;
		wake_req = 1'b1;
		t0 = $time;
		wst(dcps_pkg::ST_EXIT_WAIT, 10);
		wake_req = 1'b0;
		send(dcps_pkg::CMD_ACT);
		send(dcps_pkg::CMD_RD);
		check("rd_delay", {3'h0, ($time - t0) >= 5120ns}, 4'h1);
		send(dcps_pkg::CMD_PRE);
		wst(dcps_pkg::ST_IDLE, 60);
		check("idle", {3'h0, idle_o}, 4'h1);
	endtask
	task t_bad;
		drv2(1'b1, dcps_pkg::CMD_ACT);
		drv2(1'b1, dcps_pkg::CMD_RD);
		drv2(1'b0, dcps_pkg::CMD_REF);
		repeat (6) drv2(1'b0, 4'hF);
		check("illegal", {3'h0, ill2_seen}, 4'h1);
		check("no_sr", {3'h0, st2 == dcps_pkg::ST_SELF_REF}, 4'h0);
	endtask
	task tally_and_finish;
		if (err_total == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Reset, then the scenarios in turn
	initial begin
		lnk2.cke = 1'b1;
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = 4'hF;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		t_pd;
		t_act_pd;
		t_sr;
		t_bad;
		tally_and_finish;
	end
	// Watchdog against a hang
	initial begin
		#40us;
		err_total++;
		tally_and_finish;
	end
endmodule // dram_cke_power_state_control_tb
